// ===== pkg/swa_cfg.svh
/*
 offsets, field positions and reset values of the framing word aligner.
 assumes inclusion by bare name after the package.
*/
`ifndef SWA_CFG_SVH
`define SWA_CFG_SVH
`define SWA_OFF_CTRL 12'h000
`define SWA_OFF_PAT 12'h004
`define SWA_OFF_STAT 12'h008
`define SWA_CTRL_FLIP 0
`define SWA_CTRL_SLIP 1
`define SWA_CTRL_DW 2
`define SWA_CTRL_RST 3'h0
`define SWA_PAT_RST 16'h146F
`define SWA_STAT_LOCK 0
`define SWA_STAT_ARM 1
`define SWA_STAT_OFF 4
`endif

// ===== pkg/swa_pkg.sv
/*
 types of the framing word aligner.
 assumes nothing of its surroundings.
*/
package swa_pkg;
   typedef enum logic [1:0] {
      swa_idle = 2'b00,
      swa_armed = 2'b01,
      swa_locked = 2'b10
   } swa_state_t;
   typedef logic [2:0] swa_off_t;
endpackage

// ===== rtl/swa_word_aligner.sv
/*
 receive word aligner for scrambled framing streams, with an apb3 slave.
 assumes rx_byte_in is the deserialised, unaligned byte on pclk, least
 significant bit arrived first; control inputs may come from any domain.
*/
// The APB slave port and the register addresses were decided locally.
// Functional notes
// - enable low: boundary never moves
// - comma on boundary: pattern_hit one cycle
// - detector never moves the boundary
// - comma held A2 high byte, A1 low
// - flip option reverses bit and byte order
// - only the exact, uncomplemented comma matches
// - flip maps F628 onto 146F internally
// - select low A1A2, high A1A1A2A2
// - no select input: A1A2 mode
// - echo follows its byte out
// - enable rising edge: lock first comma
// - lock pulses pattern_hit and sync_pulse
// - locked: no re-align, pulse on other boundary
// - resync pulses until next enable edge
// - default comma is 146F
// - pattern_hit works with enable low
// - output word 8 or 16 bits
// - manual modes only: pattern or bit-slip
// - raw data, no decoding
// - slip edge: skip one earlier bit
`timescale 1ns/100ps
`include "swa_cfg.svh"
module swa_word_aligner
   import swa_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter bit FLS_USED = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] rx_byte_in,
   input wire logic comma_align_enable,
   input wire logic slip_request,
   input wire logic framing_length_select,
   output logic [15:0] aligned_word_out,
   output logic word_valid,
   output logic pattern_hit,
   output logic sync_pulse,
   output logic framing_length_echo
);

   if (ADDR_W < 4) begin : g_chk
      $error("ADDR_W too small for the register map");
   end

   // synchronisers, third stage only for edge detection
   logic [2:0] cae_sync_q;
   logic [2:0] slip_sync_q;
   logic [1:0] fls_sync_q;
   wire cae_s = cae_sync_q[1];
   wire slip_s = slip_sync_q[1];
   wire cae_rise = cae_s & ~cae_sync_q[2];
   wire slip_rise = slip_s & ~slip_sync_q[2];
   wire fls_eff = FLS_USED ? fls_sync_q[1] : 1'b0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cae_sync_q <= 3'h0;
         slip_sync_q <= 3'h0;
         fls_sync_q <= 2'h0;
      end else if (pclk_en) begin
         cae_sync_q <= {cae_sync_q[1:0], comma_align_enable};
         slip_sync_q <= {slip_sync_q[1:0], slip_request};
         fls_sync_q <= {fls_sync_q[0], framing_length_select};
      end
   end

   // configuration registers
   logic [2:0] ctrl_q;
   logic [15:0] pat_q;
   wire ctrl_flip = ctrl_q[`SWA_CTRL_FLIP];
   wire ctrl_slip = ctrl_q[`SWA_CTRL_SLIP];
   wire ctrl_dw = ctrl_q[`SWA_CTRL_DW];

   // effective comma, A2 in [15:8], A1 in [7:0]
   logic [15:0] pat_rev;
   for (genvar i = 0; i < 16; i++) begin : g_rev
      assign pat_rev[i] = pat_q[15-i];
   end
   wire [15:0] pat_eff = ctrl_flip ? pat_rev : pat_q;
   wire [31:0] pat32 = {pat_eff[15:8], pat_eff[15:8], pat_eff[7:0], pat_eff[7:0]};

   // five-byte history, oldest bits at the bottom
   logic [39:0] hist_q;
   wire [39:0] hist_d = {rx_byte_in, hist_q[39:8]};

   // pattern detector, a 16-bit and a 32-bit comparator per bit offset
   logic [7:0] hit16;
   logic [7:0] hit32;
   logic [7:0] hit_vec;
   logic [7:0] byte_at [8];
   for (genvar k = 0; k < 8; k++) begin : g_det
      assign hit16[k] = hist_q[k+31 -: 16] == pat_eff;
      assign hit32[k] = hist_q[k+31 -: 32] == pat32;
      assign hit_vec[k] = fls_eff ? hit32[k] : hit16[k];
      assign byte_at[k] = hist_q[k+31 -: 8];
   end

   function automatic swa_off_t first_one(input logic [7:0] v);
      swa_off_t r;
      r = 3'h0;
      for (int j = 7; j >= 0; j--) begin
         if (v[j]) begin
            r = swa_off_t'(j);
         end
      end
      return r;
   endfunction

   swa_state_t state_q;
   swa_state_t state_d;
   swa_off_t off_q;
   swa_off_t off_d;
   logic lock_evt;
   logic resync_evt;
   wire any_hit = |hit_vec;
   wire [7:0] cur_mask = 8'h01 << off_q;
   wire other_hit = |(hit_vec & ~cur_mask);
   wire [2:0] first_k = first_one(hit_vec);

   // alignment control, the only source of boundary moves
   always_comb begin
      state_d = state_q;
      off_d = off_q;
      lock_evt = 1'b0;
      resync_evt = 1'b0;
      if (ctrl_slip) begin
         state_d = swa_idle;
         if (slip_rise && cae_s) begin
            off_d = off_q + 3'h1;
         end
      end else begin
         case (state_q)
            swa_idle: begin
               if (cae_rise) begin
                  state_d = swa_armed;
               end
            end
            swa_armed: begin
               if (!cae_s) begin
                  state_d = swa_idle;
               end else if (any_hit) begin
                  off_d = first_k;
                  lock_evt = 1'b1;
                  state_d = swa_locked;
               end
            end
            swa_locked: begin
               if (cae_rise) begin
                  state_d = swa_armed;
               end else if (other_hit) begin
                  resync_evt = 1'b1;
               end
            end
            default: begin
               state_d = swa_idle;
            end
         endcase
      end
   end

   // datapath outputs at the new boundary
   wire [7:0] byte_sel = byte_at[off_d];
   wire hit_now = hit_vec[off_d];
   logic phase_q;
   logic [7:0] lo_q;
   logic [15:0] word_q;
   logic valid_q;
   logic hit_q;
   logic sync_q;
   logic echo_q;
   wire [15:0] word_d = ctrl_dw ? {byte_sel, lo_q} : {8'h00, byte_sel};
   wire valid_d = ctrl_dw ? phase_q : 1'b1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist_q <= 40'h0;
         state_q <= swa_idle;
         off_q <= 3'h0;
         phase_q <= 1'b0;
         lo_q <= 8'h00;
         word_q <= 16'h0000;
         valid_q <= 1'b0;
         hit_q <= 1'b0;
         sync_q <= 1'b0;
         echo_q <= 1'b0;
      end else if (pclk_en) begin
         hist_q <= hist_d;
         state_q <= state_d;
         off_q <= off_d;
         phase_q <= ctrl_dw & ~phase_q;
         lo_q <= byte_sel;
         word_q <= word_d;
         valid_q <= valid_d;
         hit_q <= hit_now;
         sync_q <= lock_evt | resync_evt;
         echo_q <= fls_eff;
      end
   end

   assign aligned_word_out = word_q;
   assign word_valid = valid_q;
   assign pattern_hit = hit_q;
   assign sync_pulse = sync_q;
   assign framing_length_echo = echo_q;

   // apb3 slave: answer one cycle into the access phase
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   wire sel_ctrl = paddr == ADDR_W'(`SWA_OFF_CTRL);
   wire sel_pat = paddr == ADDR_W'(`SWA_OFF_PAT);
   wire sel_stat = paddr == ADDR_W'(`SWA_OFF_STAT);
   wire mapped = sel_ctrl | sel_pat | sel_stat;
   wire access = psel & penable;
   wire take = access & ~pready_q;
   wire commit = access & pready_q & pwrite;
   logic [31:0] stat_word;
   always_comb begin
      stat_word = 32'h0;
      stat_word[`SWA_STAT_LOCK] = state_q == swa_locked;
      stat_word[`SWA_STAT_ARM] = state_q == swa_armed;
      stat_word[`SWA_STAT_OFF +: 3] = off_q;
   end
   wire [31:0] rd_mux = sel_ctrl ? {29'h0, ctrl_q} :
                        sel_pat ? {16'h0, pat_q} :
                        sel_stat ? stat_word : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `SWA_CTRL_RST;
         pat_q <= `SWA_PAT_RST;
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (pclk_en) begin
         pready_q <= take;
         if (take) begin
            prdata_q <= pwrite ? 32'h0 : rd_mux;
            pslverr_q <= ~mapped;
         end
         if (commit && sel_ctrl) begin
            ctrl_q <= pwdata[2:0];
         end
         if (commit && sel_pat) begin
            pat_q <= pwdata[15:0];
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_hold_boundary: assert property (pclk_en && !cae_s |=> $stable(off_q))
      else $error("boundary moved with enable low");
   a_lock_pulse: assert property (pclk_en && lock_evt |=> pattern_hit && sync_pulse)
      else $error("lock without both pulses");
   a_lock_takes: assert property (pclk_en && lock_evt |=> off_q == $past(first_k))
      else $error("lock at wrong offset");
   a_no_realign: assert property (
      pclk_en && state_q == swa_locked && !ctrl_slip |=> $stable(off_q))
      else $error("locked boundary moved");
   a_sync_cause: assert property (
      $rose(sync_pulse) |-> $past(lock_evt || resync_evt))
      else $error("sync pulse without cause");
   a_rearm_edge: assert property (
      pclk_en && state_q == swa_locked && cae_rise && !ctrl_slip |=> state_q == swa_armed)
      else $error("enable edge did not re-arm");
   a_slip_step: assert property (
      pclk_en && ctrl_slip && slip_rise && cae_s |=> off_q == $past(off_q) + 3'h1)
      else $error("slip did not advance one bit");
   a_detect_only: assert property (
      pclk_en && !ctrl_slip && state_q == swa_idle |=> $stable(off_q))
      else $error("boundary moved without alignment");
   a_default_mode: assert property (!FLS_USED |-> !framing_length_echo)
      else $error("echo high without select input");
   a_armed_drop: assert property (
      pclk_en && state_q == swa_armed && !cae_s && !ctrl_slip |=> state_q == swa_idle)
      else $error("armed state kept with enable low");
   a_idle_arm: assert property (
      pclk_en && state_q == swa_idle && cae_rise && !ctrl_slip |=> state_q == swa_armed)
      else $error("enable edge did not arm");
   a_lock_hold: assert property (
      pclk_en && state_q == swa_locked && !cae_rise && !ctrl_slip |=> state_q == swa_locked)
      else $error("lock lost without enable edge");
   a_resync_keeps: assert property (
      pclk_en && resync_evt |=> sync_pulse && $stable(off_q))
      else $error("resync without pulse or with a move");
   a_slip_gate: assert property (
      pclk_en && ctrl_slip && !slip_rise |=> $stable(off_q))
      else $error("boundary moved without slip edge");
   a_slip_idle: assert property (
      pclk_en && ctrl_slip |=> state_q == swa_idle)
      else $error("alignment active in slip mode");
   a_no_sync_idle: assert property (
      pclk_en && state_q == swa_idle |=> !sync_pulse)
      else $error("sync pulse from the detector alone");

   // datapath and clock-enable checks
   a_hit_byte: assert property (
      pclk_en && hit_now && !ctrl_dw |=> aligned_word_out[7:0] == $past(pat_eff[15:8]))
      else $error("hit not with the closing byte");
   a_hit_word: assert property (
      pclk_en && hit_now && ctrl_dw && !fls_eff && off_d == off_q |=> aligned_word_out == $past(pat_eff))
      else $error("wide word not earlier byte low");
   a_echo_follow: assert property (
      pclk_en |=> framing_length_echo == $past(fls_eff))
      else $error("echo not with its byte");
   a_valid_rate: assert property (
      pclk_en && !ctrl_dw |=> word_valid)
      else $error("narrow word not valid every cycle");
   a_word_narrow: assert property (
      pclk_en && !ctrl_dw |=> aligned_word_out[15:8] == 8'h00)
      else $error("narrow word upper byte not zero");
   a_freeze: assert property (
      !pclk_en |=> $stable(off_q) && $stable(state_q) && $stable(aligned_word_out))
      else $error("state moved with clock enable low");

   // register bus checks
   a_apb_answer: assert property (pclk_en && take |=> pready)
      else $error("apb answer missing");
   a_apb_single: assert property (
      pclk_en && pready |=> !pready)
      else $error("apb answer longer than one cycle");
   a_err_unmapped: assert property (
      pclk_en && take && !mapped |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_write_rdzero: assert property (
      pclk_en && take && pwrite |=> prdata == 32'h0)
      else $error("write returned read data");
   a_ctrl_write: assert property (
      pclk_en && commit && sel_ctrl |=> ctrl_q == $past(pwdata[2:0]))
      else $error("control write lost");
   a_pat_write: assert property (
      pclk_en && commit && sel_pat |=> pat_q == $past(pwdata[15:0]))
      else $error("pattern write lost");
   a_stat_offset: assert property (
      pclk_en && take && !pwrite && sel_stat |=> prdata[`SWA_STAT_OFF +: 3] == $past(off_q))
      else $error("status offset wrong");
   a_rd_ctrl: assert property (
      pclk_en && take && !pwrite && sel_ctrl |=> prdata == {29'h0, $past(ctrl_q)})
      else $error("control read wrong");

   c_lock: cover property (lock_evt ##1 sync_pulse);
   c_resync: cover property (resync_evt ##1 sync_pulse);
   c_slip_hit: cover property (ctrl_slip && slip_rise ##[1:4] pattern_hit);
   c_long_frame: cover property (fls_eff && lock_evt);
   c_wide_hit: cover property (ctrl_dw && hit_now);
endmodule

// ===== verification/swa_sonet_tx.sv
/*
 model of the remote framing transmitter feeding the raw byte stream.
 assumes the bench seeds the random source and queues bits by task.
*/
`timescale 1ns/100ps
module swa_sonet_tx (
   input wire logic pclk,
   input wire logic presetn,
   output logic [7:0] rx_byte
);
   bit q[$];
   logic [7:0] f;
   // least significant bit first, low byte before high
   task automatic put(input logic [31:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         q.push_back(v[i]);
      end
   endtask
   // filler never holds a run of four ones
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_byte <= 8'h00;
      end else begin
         f = 8'($urandom) & 8'h81;
         for (int i = 0; i < 8; i++) begin
            if (q.size() > 0) f[i] = q.pop_front();
         end
         rx_byte <= f;
      end
   end
endmodule

// ===== verification/tb_top.sv
/*
 self-checking bench of the framing word aligner.
 assumes the transmitter model and the aligner share one clock.
*/
`timescale 1ns/100ps
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, cae, slip, fls, err, en;
   logic [15:0] word, wh;
   logic pready, pslverr, word_valid, pattern_hit, sync_pulse, fle;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic [7:0] rx_byte;
   int n_mismatch = 0, checked = 0, nh, ns, nv;
   swa_sonet_tx i_tx (.pclk(pclk), .presetn(presetn), .rx_byte(rx_byte));
   swa_word_aligner i_swa_word_aligner (.pclk(pclk), .presetn(presetn), .pclk_en(en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_byte_in(rx_byte),
      .comma_align_enable(cae), .slip_request(slip), .framing_length_select(fls),
      .aligned_word_out(word), .word_valid(word_valid), .pattern_hit(pattern_hit),
      .sync_pulse(sync_pulse), .framing_length_echo(fle));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic win(input int n);
      nh = 0;
      ns = 0;
      nv = 0;
      wh = 16'hFFFF;
      repeat (n) begin
         @(posedge pclk);
         #1;
         if (pattern_hit === 1'b1) begin
            wh = word;
         end
         nh += (pattern_hit === 1'b1);
         ns += (sync_pulse === 1'b1);
         nv += (word_valid === 1'b1);
      end
   endtask
   task automatic comma(input int k, input logic [31:0] c, input int n);
      i_tx.put($urandom, k);
      i_tx.put(c, n);
      win(14);
   endtask
   task automatic rst();
      presetn <= 1'b0;
      cae <= 1'b0;
      slip <= 1'b0;
      fls <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      win(2);
   endtask
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #40us;
      n_mismatch++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_of_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, cae, slip, fls} = 7'h00;
      paddr = 12'h000;
      en = 1'b1;
      pwdata = 32'h0;
      void'($urandom(32'h204ECE60));
      rst();
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0000146F, "pattern reset");
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0, "status reset");
      apb(1'b0, 12'h00C, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped");
      for (int i = 0; i < 3; i++) begin
         v = $urandom & 32'hFFFF;
         apb(1'b1, 12'h004, v);
         apb(1'b0, 12'h004, 32'h0);
         chk(rd, v, "pattern readback");
      end
      apb(1'b1, 12'h004, 32'h146F);
      $display("test registers done");
      comma(0, 32'h146F, 16);
      chk(nh, 1, "hit enable low");
      chk(wh, 16'h0014, "byte at hit");
      chk(ns, 0, "sync enable low");
      comma(3, 32'h146F, 16);
      chk(nh, 0, "boundary moved");
      comma(0, 32'hEB90, 16);
      chk(nh, 0, "complement hit");
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b1, 12'h004, 32'hF628);
      comma(0, 32'h146F, 16);
      chk(nh, 1, "flip hit");
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h146F);
      $display("test detect done");
      @(posedge pclk);
      cae <= 1'b1;
      win(6);
      comma(3, 32'h146F, 16);
      chk({ns, nh}, {32'd1, 32'd1}, "lock pulses");
      apb(1'b0, 12'h008, 32'h0);
      chk(rd & 32'h1, 32'h1, "locked flag");
      comma(3, 32'h146F, 16);
      chk({ns, nh}, {32'd0, 32'd1}, "same boundary");
      comma(5, 32'h146F, 16);
      chk({ns, nh}, {32'd1, 32'd0}, "other boundary");
      @(posedge pclk);
      cae <= 1'b0;
      comma(5, 32'h146F, 16);
      chk({ns, nh}, {32'd1, 32'd0}, "resync enable low");
      @(posedge pclk);
      cae <= 1'b1;
      win(6);
      comma(5, 32'h146F, 16);
      chk({ns, nh}, {32'd1, 32'd1}, "relock");
      $display("test lock done");
      rst();
      @(posedge pclk);
      fls <= 1'b1;
      cae <= 1'b1;
      win(6);
      chk({31'h0, fle}, 32'h1, "length echo");
      comma(2, 32'h146F, 16);
      chk(ns, 0, "short pattern in long mode");
      comma(2, 32'h14146F6F, 32);
      chk(ns, 1, "long pattern lock");
      $display("test length done");
      rst();
      apb(1'b1, 12'h000, 32'h2);
      @(posedge pclk);
      cae <= 1'b1;
      win(4);
      @(posedge pclk);
      slip <= 1'b1;
      win(3);
      @(posedge pclk);
      slip <= 1'b0;
      win(3);
      comma(1, 32'h146F, 16);
      chk(nh, 1, "slip one bit");
      $display("test slip done");
      rst();
      apb(1'b1, 12'h000, 32'h4);
      win(10);
      chk(nv, 5, "double width rate");
      comma(0, 32'h146F, 16);
      chk(wh, 16'h146F, "wide word at hit");
      $display("test width done");
      @(posedge pclk);
      en <= 1'b0;
      comma(0, 32'h146F, 16);
      chk(nh, 0, "hit while frozen");
      @(posedge pclk);
      en <= 1'b1;
      $display("test enable done");
      end_of_test();
   end
endmodule
